//--- rtl/actc_top.v
// What this block does
// - First result after start is fully settled.
// - Line-rejection field applies only at lowest rate, outside turbo mode.
// - Rates and notches scale with system clock.
// - Continuous start waits 210 or 114 clocks.
// - Single-shot time counted in whole clock periods.
// - Internal oscillator adds wake-up delay in single-shot.
// - Oscillator powers up at start; conversion waits.
// - Duty-cycle single-shot uses normal-mode timing.
// - Normal-mode conversion period table.
// - Duty-cycle continuous conversion period table.
// - Turbo-mode conversion period table.
// - Two-bit reference select, internal after reset.
// - Internal reference settles before conversion proceeds.
// - Two external clock edges switch clock source.
// - Level and two route fields drive excitation sources.
// - Excitation stays on unless level zero or sleep.
// - Enabled switch closes on start, opens on sleep.
// - Clearing switch enable opens it; open after reset.
// - Burn-out enable drives both burn-out sources.
// - Modulator strobe every 16 or 8 clocks.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "actc_consts.vh"
module actc_top
#(
    parameter [15:0] OSC_PHASE_INC = 16'h68dc
)
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        ext_clk_in,
    output reg         result_ready_n,
    output reg         mod_clk_strobe,
    output reg  [1:0]  filter_reject,
    output reg  [1:0]  vref_select,
    output reg  [2:0]  excitation_current_level,
    output reg  [2:0]  excitation1_route,
    output reg  [2:0]  excitation2_route,
    output reg         excitation_enable,
    output reg         low_side_switch_closed,
    output reg         burnout_source_enable,
    output reg         clock_external,
    output reg         osc_enable
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_LEAD = 2'h1;
    localparam [1:0] ST_CONV = 2'h2;

    localparam integer WAKE_CYC   = (`ACTC_OSC_WAKE_NS * `ACTC_PCLK_MHZ) / 1000;
    localparam integer WAKE_T_CYC = (`ACTC_OSC_WAKE_T_NS * `ACTC_PCLK_MHZ) / 1000;
    localparam integer REF_CYC    = (`ACTC_REF_SETTLE_NS * `ACTC_PCLK_MHZ + 999) / 1000;

    // Period lookup; duty-cycle single-shot falls through to the normal column.
    function [19:0] conv_len;
        input [1:0] mode;
        input       single;
        input [2:0] rate;
        reg   [2:0] col;
        begin
            if (mode == `ACTC_MODE_TURBO)
                col = single ? 3'h4 : 3'h3;
            else if (single)
                col = 3'h1;
            else if (mode == `ACTC_MODE_DUTY)
                col = 3'h2;
            else
                col = 3'h0;
            case ({col, rate})
                6'h00: conv_len = `ACTC_NC0;
                6'h01: conv_len = `ACTC_NC1;
                6'h02: conv_len = `ACTC_NC2;
                6'h03: conv_len = `ACTC_NC3;
                6'h04: conv_len = `ACTC_NC4;
                6'h05: conv_len = `ACTC_NC5;
                6'h08: conv_len = `ACTC_NS0;
                6'h09: conv_len = `ACTC_NS1;
                6'h0a: conv_len = `ACTC_NS2;
                6'h0b: conv_len = `ACTC_NS3;
                6'h0c: conv_len = `ACTC_NS4;
                6'h0d: conv_len = `ACTC_NS5;
                6'h0e: conv_len = `ACTC_NS6;
                6'h10: conv_len = `ACTC_DC0;
                6'h11: conv_len = `ACTC_DC1;
                6'h12: conv_len = `ACTC_DC2;
                6'h13: conv_len = `ACTC_DC3;
                6'h14: conv_len = `ACTC_DC4;
                6'h15: conv_len = `ACTC_DC5;
                6'h16: conv_len = `ACTC_DC6;
                6'h18: conv_len = `ACTC_TC0;
                6'h19: conv_len = `ACTC_TC1;
                6'h1a: conv_len = `ACTC_TC2;
                6'h1b: conv_len = `ACTC_TC3;
                6'h1c: conv_len = `ACTC_TC4;
                6'h1d: conv_len = `ACTC_TC5;
                6'h1e: conv_len = `ACTC_TC6;
                6'h20: conv_len = `ACTC_TS0;
                6'h21: conv_len = `ACTC_TS1;
                6'h22: conv_len = `ACTC_TS2;
                6'h23: conv_len = `ACTC_TS3;
                6'h24: conv_len = `ACTC_TS4;
                6'h25: conv_len = `ACTC_TS5;
                6'h26: conv_len = `ACTC_TS6;
                default: conv_len = (col == 3'h1) ? `ACTC_NS6 : `ACTC_NC6;
            endcase
        end
    endfunction

    function is_reg;
        input [7:0] addr;
        input [7:0] off;
        begin
            is_reg = (addr == off);
        end
    endfunction

    reg  [`ACTC_CTRL_W-1:0] ctrl_q;
    reg  [`ACTC_CTRL_W-1:0] ctrl_d;
    reg  [1:0]              state_q;
    reg  [19:0]             cnt_q;
    reg  [9:0]              wake_q;
    reg  [9:0]              ref_q;
    reg  [3:0]              mod_cnt_q;
    reg  [15:0]             phase_q;
    reg                     osc_tick_q;
    reg  [1:0]              ext_edges_q;
    reg                     osc_on_q;
    reg                     sleep_q;
    reg                     sleep_d;
    wire                    ext_rise;
    wire [16:0]             phase_sum;

    wire       access   = psel & penable;
    wire       taken    = access & pready;
    wire       wr_take  = taken & pwrite;
    wire       rd_take  = taken & ~pwrite;
    wire       cfg_wr   = wr_take & is_reg(paddr, `ACTC_OFF_CTRL);
    wire       cmd_wr   = wr_take & is_reg(paddr, `ACTC_OFF_CMD);
    wire       reset_cmd = cmd_wr & pwdata[`ACTC_C_RESET];
    wire       sleep_cmd = cmd_wr & pwdata[`ACTC_C_SLEEP] & ~reset_cmd;
    wire       start_cmd = cmd_wr & pwdata[`ACTC_C_START] & ~reset_cmd & ~pwdata[`ACTC_C_SLEEP];
    // A configuration write during a conversion restarts it.
    wire       start_evt = start_cmd | (cfg_wr & (state_q != ST_IDLE));
    wire       status_rd = rd_take & is_reg(paddr, `ACTC_OFF_STATUS);

    wire [1:0] mode     = ctrl_q[`ACTC_F_OPMODE+:2];
    wire       turbo    = (mode == `ACTC_MODE_TURBO);
    wire       single   = ~ctrl_q[`ACTC_F_CONT];
    wire [2:0] rate     = ctrl_q[`ACTC_F_RATE+:3];
    wire [1:0] mode_n   = ctrl_d[`ACTC_F_OPMODE+:2];
    wire       single_n = ~ctrl_d[`ACTC_F_CONT];
    // The conversion clock: internal oscillator phase or the adopted external clock.
    wire       sys_tick = clock_external ? ext_rise : osc_tick_q;
    wire       hold     = (wake_q != 10'h000) | (ref_q != 10'h000);
    wire       run_tick = sys_tick & ~hold;

    assign phase_sum = {1'b0, phase_q} + {1'b0, OSC_PHASE_INC};

    actc_sync_rise u_ext_sync
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (ext_clk_in),
        .rise_q   (ext_rise)
    );

    always @*
    begin
        ctrl_d = ctrl_q;
        if (reset_cmd)
            ctrl_d = `ACTC_CTRL_RST;
        else if (cfg_wr)
            ctrl_d = pwdata[`ACTC_CTRL_W-1:0];
        sleep_d = sleep_q;
        if (reset_cmd | start_cmd)
            sleep_d = 1'b0;
        else if (sleep_cmd)
            sleep_d = 1'b1;
    end

    // Bus slave: one wait state, so every access phase lasts two cycles.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= access & ~pready;
            pslverr <= access & ~pready & ~is_reg(paddr, `ACTC_OFF_CTRL)
                       & ~is_reg(paddr, `ACTC_OFF_CMD) & ~is_reg(paddr, `ACTC_OFF_STATUS);
            prdata  <= 32'h00000000;
            if (access & ~pready & ~pwrite)
            begin
                if (is_reg(paddr, `ACTC_OFF_CTRL))
                    prdata <= {11'h000, ctrl_q};
                else if (is_reg(paddr, `ACTC_OFF_STATUS))
                    prdata <= {26'h0000000, low_side_switch_closed, osc_enable,
                               hold, clock_external, state_q != ST_IDLE, result_ready_n};
            end
        end
    end

    // Clock source: two edges on the pin adopt it until a reset or reset command.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_q        <= 16'h0000;
            osc_tick_q     <= 1'b0;
            ext_edges_q    <= 2'h0;
            clock_external <= 1'b0;
        end
        else
        begin
            phase_q    <= phase_sum[15:0];
            osc_tick_q <= phase_sum[16];
            if (reset_cmd)
            begin
                ext_edges_q    <= 2'h0;
                clock_external <= 1'b0;
            end
            else if (ext_rise & ~clock_external)
            begin
                ext_edges_q <= ext_edges_q + 2'h1;
                if (ext_edges_q == 2'h1)
                    clock_external <= 1'b1;
            end
        end
    end

    // Configuration outputs and power sequencing of the switch and sources.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q                   <= `ACTC_CTRL_RST;
            sleep_q                  <= 1'b0;
            vref_select              <= 2'h0;
            filter_reject            <= 2'h0;
            excitation_current_level <= 3'h0;
            excitation1_route        <= 3'h0;
            excitation2_route        <= 3'h0;
            excitation_enable        <= 1'b0;
            low_side_switch_closed   <= 1'b0;
            burnout_source_enable    <= 1'b0;
        end
        else
        begin
            ctrl_q      <= ctrl_d;
            sleep_q     <= sleep_d;
            vref_select <= ctrl_d[`ACTC_F_VREF+:2];
            if ((ctrl_d[`ACTC_F_RATE+:3] == 3'h0) && (mode_n != `ACTC_MODE_TURBO))
                filter_reject <= ctrl_d[`ACTC_F_LREJ+:2];
            else
                filter_reject <= 2'h0;
            excitation_current_level <= ctrl_d[`ACTC_F_LEVEL+:3];
            excitation1_route        <= ctrl_d[`ACTC_F_ROUTE1+:3];
            excitation2_route        <= ctrl_d[`ACTC_F_ROUTE2+:3];
            excitation_enable <= (ctrl_d[`ACTC_F_LEVEL+:3] != 3'h0) & ~sleep_d;
            if (!ctrl_d[`ACTC_F_PSW])
                low_side_switch_closed <= 1'b0;
            else if (sleep_cmd)
                low_side_switch_closed <= 1'b0;
            else if (start_cmd)
                low_side_switch_closed <= 1'b1;
            burnout_source_enable <= ctrl_d[`ACTC_F_BCS];
        end
    end

    // Conversion sequencer, counting system clock periods.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q        <= ST_IDLE;
            cnt_q          <= 20'h00000;
            wake_q         <= 10'h000;
            ref_q          <= REF_CYC[9:0];
            osc_on_q       <= 1'b0;
            osc_enable     <= 1'b0;
            result_ready_n <= 1'b1;
        end
        else
        begin
            if (wake_q != 10'h000)
                wake_q <= wake_q - 10'h001;
            if (ref_q != 10'h000)
                ref_q <= ref_q - 10'h001;
            if (status_rd)
                result_ready_n <= 1'b1;
            if (reset_cmd | sleep_cmd)
            begin
                state_q  <= ST_IDLE;
                osc_on_q <= 1'b0;
                wake_q   <= 10'h000;
                if (reset_cmd)
                    ref_q <= REF_CYC[9:0];
            end
            else if (start_evt)
            begin
                result_ready_n <= 1'b1;
                osc_on_q       <= 1'b1;
                if (single_n)
                begin
                    state_q <= ST_CONV;
                    cnt_q   <= conv_len(mode_n, 1'b1, ctrl_d[`ACTC_F_RATE+:3]);
                end
                else
                begin
                    state_q <= ST_LEAD;
                    cnt_q   <= (mode_n == `ACTC_MODE_TURBO) ? `ACTC_LEAD_TURBO
                                                             : `ACTC_LEAD_NORM;
                end
                // Wake time is the worst case, paid only while the oscillator sleeps.
                if (!osc_on_q && !clock_external)
                    wake_q <= (mode_n == `ACTC_MODE_TURBO) ? WAKE_T_CYC[9:0]
                                                            : WAKE_CYC[9:0];
                if (sleep_q ||
                    (cfg_wr && ctrl_q[`ACTC_F_VREF+:2] != 2'h0
                     && ctrl_d[`ACTC_F_VREF+:2] == 2'h0))
                    ref_q <= REF_CYC[9:0];
            end
            else
            begin
                if (cfg_wr && ctrl_q[`ACTC_F_VREF+:2] != 2'h0 && ctrl_d[`ACTC_F_VREF+:2] == 2'h0)
                    ref_q <= REF_CYC[9:0];
                case (state_q)
                    ST_IDLE:
                        cnt_q <= cnt_q;
                    ST_LEAD:
                        if (run_tick)
                        begin
                            if (cnt_q == 20'h00001)
                            begin
                                state_q <= ST_CONV;
                                cnt_q   <= conv_len(mode, 1'b0, rate);
                            end
                            else
                                cnt_q <= cnt_q - 20'h00001;
                        end
                    ST_CONV:
                        if (run_tick)
                        begin
                            if (cnt_q == 20'h00001)
                            begin
                                // The filter settles in one period, so every result is valid.
                                result_ready_n <= 1'b0;
                                if (single)
                                begin
                                    state_q  <= ST_IDLE;
                                    osc_on_q <= 1'b0;
                                end
                                else
                                    cnt_q <= conv_len(mode, 1'b0, rate);
                            end
                            else
                            begin
                                // Rise ahead of the next fall so falling edges mark periods.
                                if (cnt_q == 20'h00002 && !single)
                                    result_ready_n <= 1'b1;
                                cnt_q <= cnt_q - 20'h00001;
                            end
                        end
                    default:
                        state_q <= ST_IDLE;
                endcase
            end
            osc_enable <= osc_on_q & ~clock_external & ~(ext_rise & ext_edges_q[0]);
        end
    end

    // Modulator strobe: one pulse per 16 system clocks, or per 8 in turbo.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mod_cnt_q      <= 4'h0;
            mod_clk_strobe <= 1'b0;
        end
        else
        begin
            mod_clk_strobe <= 1'b0;
            if (start_evt | (state_q == ST_IDLE))
                mod_cnt_q <= 4'h0;
            else if (run_tick)
            begin
                if (mod_cnt_q >= (turbo ? `ACTC_MOD_TOP_TURBO : `ACTC_MOD_TOP_NORM))
                begin
                    mod_cnt_q      <= 4'h0;
                    mod_clk_strobe <= 1'b1;
                end
                else
                    mod_cnt_q <= mod_cnt_q + 4'h1;
            end
        end
    end
endmodule

//--- rtl/actc_consts.vh
`ifndef ACTC_CONSTS_VH
`define ACTC_CONSTS_VH

// Register byte offsets.
`define ACTC_OFF_CTRL       8'h00
`define ACTC_OFF_CMD        8'h04
`define ACTC_OFF_STATUS     8'h08

// Control register field positions (least significant bit of each field).
`define ACTC_F_RATE         0
`define ACTC_F_OPMODE       3
`define ACTC_F_CONT         5
`define ACTC_F_LREJ         6
`define ACTC_F_VREF         8
`define ACTC_F_LEVEL        10
`define ACTC_F_ROUTE1       13
`define ACTC_F_ROUTE2       16
`define ACTC_F_PSW          19
`define ACTC_F_BCS          20
`define ACTC_CTRL_W         21
`define ACTC_CTRL_RST       21'h000000

// Command register bits.
`define ACTC_C_START        0
`define ACTC_C_SLEEP        1
`define ACTC_C_RESET        2

// Status register bits.
`define ACTC_S_READY_N      0
`define ACTC_S_BUSY         1
`define ACTC_S_EXT          2
`define ACTC_S_REF          3
`define ACTC_S_OSC          4
`define ACTC_S_SWITCH       5

// Operating modes.
`define ACTC_MODE_NORMAL    2'h0
`define ACTC_MODE_DUTY      2'h1
`define ACTC_MODE_TURBO     2'h2

// Times and bus clock.
`define ACTC_PCLK_MHZ       10
`define ACTC_OSC_WAKE_NS    50000
`define ACTC_OSC_WAKE_T_NS  25000
`define ACTC_REF_SETTLE_NS  25000

// Counts in system clock periods.
`define ACTC_LEAD_NORM      20'd210
`define ACTC_LEAD_TURBO     20'd114
`define ACTC_MOD_TOP_NORM   4'hf
`define ACTC_MOD_TOP_TURBO  4'h7

// Conversion periods: N normal, D duty-cycle, T turbo; C continuous, S single-shot.
`define ACTC_NC0 20'd204768
`define ACTC_NC1 20'd91120
`define ACTC_NC2 20'd46128
`define ACTC_NC3 20'd23664
`define ACTC_NC4 20'd12464
`define ACTC_NC5 20'd6896
`define ACTC_NC6 20'd4144
`define ACTC_NS0 20'd204850
`define ACTC_NS1 20'd91218
`define ACTC_NS2 20'd46226
`define ACTC_NS3 20'd23762
`define ACTC_NS4 20'd12562
`define ACTC_NS5 20'd6994
`define ACTC_NS6 20'd4242
`define ACTC_DC0 20'd823120
`define ACTC_DC1 20'd364560
`define ACTC_DC2 20'd184592
`define ACTC_DC3 20'd94736
`define ACTC_DC4 20'd49936
`define ACTC_DC5 20'd27664
`define ACTC_DC6 20'd16656
`define ACTC_TC0 20'd102384
`define ACTC_TC1 20'd45560
`define ACTC_TC2 20'd23064
`define ACTC_TC3 20'd11832
`define ACTC_TC4 20'd6232
`define ACTC_TC5 20'd3448
`define ACTC_TC6 20'd2072
`define ACTC_TS0 20'd102434
`define ACTC_TS1 20'd45618
`define ACTC_TS2 20'd23122
`define ACTC_TS3 20'd11890
`define ACTC_TS4 20'd6290
`define ACTC_TS5 20'd3506
`define ACTC_TS6 20'd2130

`endif

//--- rtl/actc_sync_rise.v
`timescale 1ns/1ps
// Two-flop synchroniser followed by a rising-edge detector on the settled copy.
module actc_sync_rise
(
    input  wire pclk,
    input  wire presetn,
    input  wire async_in,
    output reg  rise_q
);
    reg meta_q;
    reg sync_q;
    reg last_q;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
            rise_q <= 1'b0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
            rise_q <= sync_q & ~last_q;
        end
    end
endmodule

//--- test/actc_checker.sv
`timescale 1ns/1ps
module actc_checker
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        result_ready_n,
    input wire logic        mod_clk_strobe,
    input wire logic [1:0]  filter_reject,
    input wire logic [1:0]  vref_select,
    input wire logic [2:0]  excitation_current_level,
    input wire logic [2:0]  excitation1_route,
    input wire logic [2:0]  excitation2_route,
    input wire logic        excitation_enable,
    input wire logic        low_side_switch_closed,
    input wire logic        burnout_source_enable,
    input wire logic        clock_external,
    input wire logic        osc_enable
);
    logic [20:0] cfg_q;
    wire         acc     = psel && penable && pready && pwrite;
    wire         wr_ctrl = acc && paddr == 8'h00;
    wire         wr_cmd  = acc && paddr == 8'h04;
    wire         wr_rst  = wr_cmd && pwdata[2];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            cfg_q <= 21'h000000;
        else if (wr_ctrl)
            cfg_q <= pwdata[20:0];
    access_wait_a: assert property (psel && penable && !$past(penable) |=> pready)
        else $error("no pready");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready too long");
    err_decode_a: assert property (pready && psel |->
        pslverr == !(paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08))
        else $error("bad pslverr");
    vref_follow_a: assert property (wr_ctrl |-> ##2 vref_select == cfg_q[9:8])
        else $error("bad vref_select");
    reject_rate_a: assert property (wr_ctrl |-> ##2 filter_reject ==
        ((cfg_q[2:0] == 3'h0 && cfg_q[4:3] != 2'h2) ? cfg_q[7:6] : 2'h0))
        else $error("bad filter_reject");
    level_route_a: assert property (wr_ctrl |-> ##2
        {excitation2_route, excitation1_route, excitation_current_level} == cfg_q[18:10])
        else $error("bad excitation fields");
    burnout_follow_a: assert property (wr_ctrl |-> ##2 burnout_source_enable == cfg_q[20])
        else $error("bad burnout enable");
    switch_clear_a: assert property (wr_ctrl && !pwdata[19] |-> ##2 !low_side_switch_closed)
        else $error("switch not opened");
    sleep_off_a: assert property (wr_cmd && pwdata[1] |-> ##2
        !excitation_enable && !low_side_switch_closed)
        else $error("sleep left outputs on");
    exc_level_a: assert property (excitation_enable |-> excitation_current_level != 3'h0)
        else $error("excitation on with zero level");
    ext_hold_a: assert property (clock_external && !wr_rst && !$past(wr_rst) |=>
        clock_external)
        else $error("external clock dropped");
    osc_excl_a: assert property (!(osc_enable && clock_external))
        else $error("oscillator on with external clock");
    strobe_pulse_a: assert property (mod_clk_strobe |=> !mod_clk_strobe)
        else $error("strobe too long");
    cover property ($rose(low_side_switch_closed));
    cover property ($rose(clock_external));
    cover property ($fell(result_ready_n));
endmodule

bind actc_top actc_checker actc_checker_i
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .result_ready_n(result_ready_n), .mod_clk_strobe(mod_clk_strobe),
    .filter_reject(filter_reject), .vref_select(vref_select),
    .excitation_current_level(excitation_current_level),
    .excitation1_route(excitation1_route), .excitation2_route(excitation2_route),
    .excitation_enable(excitation_enable), .low_side_switch_closed(low_side_switch_closed),
    .burnout_source_enable(burnout_source_enable), .clock_external(clock_external),
    .osc_enable(osc_enable)
);

//--- test/actc_ext_clk.sv
`timescale 1ns/1ps
module actc_ext_clk
#(
    parameter HALF_NS = 200
)
(
    input  wire logic run,
    output logic      clk_out
);
    // Held low while stopped, so a reset leaves the block on its oscillator.
    initial clk_out = 1'b0;
    always
    begin
        #(HALF_NS);
        clk_out = run ? ~clk_out : 1'b0;
    end
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        run;
    logic        err;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] rd;
    wire  [31:0] prdata;
    wire  [1:0]  rej, vref;
    wire  [2:0]  lvl, rt1, rt2;
    wire         pready, pslverr, xclk, rrn, strobe, exc, sw, bo, ext, osc;
    int          miscompares;
    int          checks;
    int          n;

    actc_ext_clk actc_ext_clk_i (.run(run), .clk_out(xclk));
    actc_top actc_top_i
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_clk_in(xclk),
        .result_ready_n(rrn), .mod_clk_strobe(strobe), .filter_reject(rej),
        .vref_select(vref), .excitation_current_level(lvl),
        .excitation1_route(rt1), .excitation2_route(rt2),
        .excitation_enable(exc), .low_side_switch_closed(sw),
        .burnout_source_enable(bo), .clock_external(ext), .osc_enable(osc)
    );

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task step;
        @(posedge pclk);
        n++;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task t_reset;
        chk("rrn", rrn, 1'b1);
        chk("sw", sw, 1'b0);
        chk("vref", vref, 2'h0);
        chk("ext", ext, 1'b0);
    endtask

    task t_regs;
        apb(1'b1, 8'h00, 32'h0015ae80);
        chk("rej", rej, 2'h2);
        chk("vref", vref, 2'h2);
        chk("exc", {rt2, rt1, lvl}, 9'h16b);
        chk("bo", bo, 1'b1);
        apb(1'b1, 8'h10, 32'h00000000);
        chk("err", err, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl", rd, 32'h0015ae80);
        apb(1'b1, 8'h00, 32'h0015ac90);
        chk("rej_turbo", rej, 2'h0);
        apb(1'b1, 8'h00, 32'h00000081);
        chk("rej_rate", rej, 2'h0);
        chk("bo", bo, 1'b0);
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    endtask

    task t_switch;
        apb(1'b1, 8'h00, 32'h00080400);
        apb(1'b1, 8'h04, 32'h1);
        chk("sw_start", sw, 1'b1);
        chk("exc_on", exc, 1'b1);
        apb(1'b1, 8'h00, 32'h00000400);
        chk("sw_clear", sw, 1'b0);
        apb(1'b1, 8'h00, 32'h00080400);
        apb(1'b1, 8'h04, 32'h1);
        apb(1'b1, 8'h04, 32'h2);
        chk("sw_sleep", sw, 1'b0);
        chk("exc_sleep", exc, 1'b0);
        apb(1'b1, 8'h00, 32'h00000000);
        apb(1'b1, 8'h04, 32'h1);
        chk("exc_zero", exc, 1'b0);
        apb(1'b1, 8'h04, 32'h2);
    endtask

    task t_ext;
        run <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("ext", ext, 1'b1);
        chk("osc", osc, 1'b0);
    endtask

    task conv(input logic [31:0] cfg, input int cyc);
        apb(1'b1, 8'h00, cfg);
        apb(1'b1, 8'h04, 32'h1);
        n = 4;
        while (rrn !== 1'b0 && n < cyc + 900)
            step;
        chk("conv_time", n >= cyc - 8 && n <= cyc + 800, 1'b1);
    endtask

    task t_conv;
        conv(32'h06, 4242 * 4);
        conv(32'h0e, 4242 * 4);
        conv(32'h16, 2130 * 4);
    endtask

    task t_cont;
        int s;
        conv(32'h36, (114 + 2072) * 4);
        n = 0;
        while (rrn !== 1'b1 && n < 9000)
            step;
        while (rrn !== 1'b0 && n < 9000)
            step;
        chk("period", n >= 2072 * 4 - 6 && n <= 2072 * 4 + 6, 1'b1);
        s = 0;
        repeat (320) @(posedge pclk) s += (strobe === 1'b1);
        chk("strobes", s >= 9 && s <= 11, 1'b1);
        apb(1'b1, 8'h04, 32'h2);
    endtask

    task t_rst_cmd;
        run <= 1'b0;
        repeat (10) @(posedge pclk);
        apb(1'b1, 8'h04, 32'h4);
        chk("ext_back", ext, 1'b0);
        chk("vref_back", vref, 2'h0);
    endtask

    task end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        run = 1'b0;
        miscompares = 0;
        checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_regs;
        t_switch;
        t_ext;
        t_conv;
        t_cont;
        t_rst_cmd;
        end_of_test;
    end

    initial
    begin
        repeat (100000) @(posedge pclk);
        miscompares++;
        end_of_test;
    end
endmodule
